// [hw/daf_formatter.sv]
// Output formatter of a two-channel 12-bit converter: strobe capture,
// stabilizer lock, nap detect and full-rate / double-rate output engine.
// Assumes the strobe clock is the positive strobe pin; pins are asynchronous.
//
// Behaviour
// - Both channels captured on one shared strobe edge, one word per request/acknowledge handshake.
// - Capture happens on the rising edge of the positive strobe.
// - Three formats, chosen by output setting or by serial-clock strap level.
// - Under strap configuration the double-rate single-ended format is unavailable.
// - Strobe stopped or below about 500 kHz puts the device in nap.
// - Enabled stabilizer needs one hundred strobes to relock after rate change.
// - Stabilizer enabled by clock setting, or by chip-select strap level.
// - Stabilizer accepts 30-70% duty and gives a 50% internal clock; here capture uses only strobe rising edges and no internal clock is made.
// - Grounded negative strobe input selects single-ended strobe mode.
// - Full rate: twelve bits per channel, own flags, complementary clock pair.
// - Full rate outputs change on the falling edge of the forwarded clock.
// - Double-rate single-ended: two bits per pin, six pins per channel.
// - Double rate: even bit while clock low, odd bit while high.
// - Double rate: both channel flags share one output.
// - Shared flag: channel two while clock low, channel one while high.
// - Differential: six pairs per channel plus flag and clock pairs.
`timescale 1ns/1ns
module daf_formatter import daf_pkg::*; #(
	parameter int FIFO_DEPTH = DAF_FIFO_DEPTH,
	parameter int LOCK_CYC   = DAF_LOCK_CYC,
	parameter int NAP_CYC    = DAF_NAP_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  sample_strobe_pos,
	input  wire logic                  sample_strobe_neg,
	input  wire logic [DAF_DATA_W-1:0] ch1_sample,
	input  wire logic [DAF_DATA_W-1:0] ch2_sample,
	input  wire logic                  ch1_over,
	input  wire logic                  ch2_over,
	input  wire logic                  config_select_strap,
	input  wire logic                  cs_strap_level,
	input  wire logic                  sck_strap_level,
	input  wire logic                  clock_ctrl_setting,
	input  wire logic [1:0]            output_ctrl_setting,
	input  wire logic                  rate_change,
	input  wire logic                  output_hold,
	output logic [DAF_DATA_W-1:0]      ch1_bit_r,
	output logic [DAF_DATA_W-1:0]      ch2_bit_r,
	output logic [DAF_PAIR_W-1:0]      ch1_pair_r,
	output logic [DAF_PAIR_W-1:0]      ch1_pair_n_r,
	output logic [DAF_PAIR_W-1:0]      ch2_pair_r,
	output logic [DAF_PAIR_W-1:0]      ch2_pair_n_r,
	output logic                       ch1_range_flag_r,
	output logic                       ch2_range_flag_r,
	output logic                       shared_range_flag_r,
	output logic                       shared_range_flag_n_r,
	output logic                       fwd_clock_pos_r,
	output logic                       fwd_clock_neg_r,
	output logic                       sample_reliable_r,
	output daf_fmt_type                format_r,
	output logic                       dcs_en_r,
	output logic                       dcs_locked_r,
	output logic                       nap_r,
	output logic                       single_ended_r
);
	typedef logic [DAF_WORD_W-1:0] daf_word_type;

	function automatic logic [DAF_PAIR_W-1:0] pick_bits(logic [DAF_DATA_W-1:0] d, logic odd);
		logic [DAF_PAIR_W-1:0] r;
		r = '0;
		for (int i = 0; i < DAF_PAIR_W; i++) begin
			r[i] = d[2*i + int'(odd)];
		end
		return r;
	endfunction

	// ***************
	// Strobe domain
	// ***************
	logic         st_act_r, st_act_nxt, st_req_r, st_req_nxt;
	logic         st_ack_s1_r, st_ack_s2_r, st_rl_s1_r, st_rl_s2_r, st_rl_prev_r;
	logic         st_dcs_s1_r, st_dcs_s2_r, st_dcs_prev_r;
	logic         st_locked_r, st_locked_nxt;
	logic [DAF_LOCK_W-1:0] st_cnt_r, st_cnt_nxt;
	daf_word_type st_word_r, st_word_nxt;
	logic         ack_r, ack_nxt, rl_tgl_r, rl_tgl_nxt;

	always_comb begin
		st_act_nxt    = ~st_act_r;
		st_req_nxt    = st_req_r;
		st_word_nxt   = st_word_r;
		st_cnt_nxt    = st_cnt_r;
		st_locked_nxt = st_locked_r;
		if (st_req_r == st_ack_s2_r) begin
			st_word_nxt = {~st_locked_r, ch2_over, ch1_over, ch2_sample, ch1_sample};
			st_req_nxt  = ~st_req_r;
		end
		if (!st_dcs_s2_r) begin
			st_locked_nxt = 1'b1;
			st_cnt_nxt    = '0;
		end else if (st_rl_s2_r != st_rl_prev_r || !st_dcs_prev_r) begin
			st_locked_nxt = 1'b0;
			st_cnt_nxt    = '0;
		end else if (!st_locked_r) begin
			if (st_cnt_r == DAF_LOCK_W'(LOCK_CYC - 1)) begin
				st_locked_nxt = 1'b1;
			end else begin
				st_cnt_nxt = st_cnt_r + 1'b1;
			end
		end
	end

	// Only rising edges used, duty irrelevant
	always_ff @(posedge sample_strobe_pos or negedge arst_n) begin
		if (!arst_n) begin
			st_act_r      <= 1'b0;
			st_req_r      <= 1'b0;
			st_word_r     <= '0;
			st_ack_s1_r   <= 1'b0;
			st_ack_s2_r   <= 1'b0;
			st_rl_s1_r    <= 1'b0;
			st_rl_s2_r    <= 1'b0;
			st_rl_prev_r  <= 1'b0;
			st_dcs_s1_r   <= 1'b0;
			st_dcs_s2_r   <= 1'b0;
			st_dcs_prev_r <= 1'b0;
			st_locked_r   <= 1'b1;
			st_cnt_r      <= '0;
		end else begin
			st_act_r      <= st_act_nxt;
			st_req_r      <= st_req_nxt;
			st_word_r     <= st_word_nxt;
			st_ack_s1_r   <= ack_r;
			st_ack_s2_r   <= st_ack_s1_r;
			st_rl_s1_r    <= rl_tgl_r;
			st_rl_s2_r    <= st_rl_s1_r;
			st_rl_prev_r  <= st_rl_s2_r;
			st_dcs_s1_r   <= dcs_en_r;
			st_dcs_s2_r   <= st_dcs_s1_r;
			st_dcs_prev_r <= st_dcs_s2_r;
			st_locked_r   <= st_locked_nxt;
			st_cnt_r      <= st_cnt_nxt;
		end
	end

	// ***************
	// Control domain: sync, config, nap
	// ***************
	logic [DAF_P_W-1:0]   pin_s1_r, pin_s2_r, s;
	logic [DAF_NAP_W-1:0] idle_r, idle_nxt;
	logic                 act_prev_r, rate_prev_r, nap_nxt, cfg_strap_r, dcs_en_nxt;
	logic                 fifo_in_ready, fifo_push;
	daf_fmt_type          format_nxt;

	always_comb begin
		s          = pin_s2_r;
		ack_nxt    = ack_r;
		fifo_push  = 1'b0;
		// Word taken only when the buffer has room
		if (s[DAF_P_REQ] != ack_r && fifo_in_ready) begin
			fifo_push = 1'b1;
			ack_nxt   = s[DAF_P_REQ];
		end
		idle_nxt = idle_r;
		nap_nxt  = nap_r;
		if (s[DAF_P_ACT] != act_prev_r) begin
			idle_nxt = '0;
			nap_nxt  = 1'b0;
		end else if (idle_r == DAF_NAP_W'(NAP_CYC - 1)) begin
			nap_nxt = 1'b1;
		end else begin
			idle_nxt = idle_r + 1'b1;
		end
		// Relock on restart or rate change
		rl_tgl_nxt = rl_tgl_r;
		if ((nap_r && !nap_nxt) || (s[DAF_P_RATE] && !rate_prev_r)) begin
			rl_tgl_nxt = ~rl_tgl_r;
		end
		dcs_en_nxt = s[DAF_P_STRAP] ? s[DAF_P_CS] : s[DAF_P_DCS];
		if (s[DAF_P_STRAP]) begin
			format_nxt = s[DAF_P_SCK] ? DAF_FMT_DDR_DIF : DAF_FMT_FULL;
		end else begin
			unique case (s[DAF_P_FMT +: 2])
				2'b00: format_nxt = DAF_FMT_FULL;
				2'b01: format_nxt = DAF_FMT_DDR_SE;
				2'b10: format_nxt = DAF_FMT_DDR_DIF;
				default: format_nxt = DAF_FMT_FULL;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_r       <= '0;
			pin_s2_r       <= '0;
			ack_r          <= 1'b0;
			idle_r         <= '0;
			nap_r          <= 1'b0;
			act_prev_r     <= 1'b0;
			rate_prev_r    <= 1'b0;
			rl_tgl_r       <= 1'b0;
			cfg_strap_r    <= 1'b0;
			dcs_en_r       <= 1'b0;
			format_r       <= DAF_FMT_RST;
			dcs_locked_r   <= 1'b0;
			single_ended_r <= 1'b0;
		end else begin
			pin_s1_r       <= {st_locked_r, st_act_r, st_req_r, output_hold, rate_change,
				sample_strobe_neg, output_ctrl_setting, clock_ctrl_setting,
				sck_strap_level, cs_strap_level, config_select_strap};
			pin_s2_r       <= pin_s1_r;
			ack_r          <= ack_nxt;
			idle_r         <= idle_nxt;
			nap_r          <= nap_nxt;
			act_prev_r     <= s[DAF_P_ACT];
			rate_prev_r    <= s[DAF_P_RATE];
			rl_tgl_r       <= rl_tgl_nxt;
			cfg_strap_r    <= s[DAF_P_STRAP];
			dcs_en_r       <= dcs_en_nxt;
			format_r       <= format_nxt;
			dcs_locked_r   <= s[DAF_P_LOCK];
			single_ended_r <= ~s[DAF_P_NEG];
		end
	end

	// ***************
	// Buffer
	// ***************
	logic         fifo_out_valid, fifo_out_ready;
	daf_word_type fifo_out_data;

	daf_fifo #(.W(DAF_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (st_word_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ***************
	// Output engine
	// ***************
	daf_word_type          cur_r, cur_nxt, src;
	logic [DAF_DATA_W-1:0] b1_nxt, b2_nxt;
	logic [DAF_PAIR_W-1:0] p1_nxt, p1n_nxt, p2_nxt, p2n_nxt;
	logic                  f1_nxt, f2_nxt, fs_nxt, fsn_nxt, fwd_nxt, rel_nxt, run, pres, hi;

	always_comb begin
		run            = !nap_r && !s[DAF_P_HOLD];
		fifo_out_ready = run && fwd_clock_pos_r;
		hi             = !fwd_clock_pos_r;
		src            = fwd_clock_pos_r ? fifo_out_data : cur_r;
		pres           = run && (hi || fifo_out_valid);
		cur_nxt = cur_r;
		fwd_nxt = fwd_clock_pos_r;
		b1_nxt  = ch1_bit_r;
		b2_nxt  = ch2_bit_r;
		f1_nxt  = ch1_range_flag_r;
		f2_nxt  = ch2_range_flag_r;
		p1_nxt  = ch1_pair_r;
		p1n_nxt = ch1_pair_n_r;
		p2_nxt  = ch2_pair_r;
		p2n_nxt = ch2_pair_n_r;
		fs_nxt  = shared_range_flag_r;
		fsn_nxt = shared_range_flag_n_r;
		rel_nxt = sample_reliable_r;
		if (pres) begin
			cur_nxt = src;
			fwd_nxt = hi;
			rel_nxt = ~src[DAF_W_UNREL];
			// Flags travel in the data word
			if (format_r == DAF_FMT_FULL) begin
				if (!hi) begin
					b1_nxt = src[DAF_W_CH1 +: DAF_DATA_W];
					b2_nxt = src[DAF_W_CH2 +: DAF_DATA_W];
					f1_nxt = src[DAF_W_OF1];
					f2_nxt = src[DAF_W_OF2];
				end
				p1_nxt  = '0;
				p1n_nxt = '0;
				p2_nxt  = '0;
				p2n_nxt = '0;
				fs_nxt  = 1'b0;
				fsn_nxt = 1'b0;
			end else begin
				p1_nxt = pick_bits(src[DAF_W_CH1 +: DAF_DATA_W], hi);
				p2_nxt = pick_bits(src[DAF_W_CH2 +: DAF_DATA_W], hi);
				// Channel two low, channel one high
				fs_nxt = hi ? src[DAF_W_OF1] : src[DAF_W_OF2];
				p1n_nxt = (format_r == DAF_FMT_DDR_DIF) ? ~p1_nxt : '0;
				p2n_nxt = (format_r == DAF_FMT_DDR_DIF) ? ~p2_nxt : '0;
				fsn_nxt = (format_r == DAF_FMT_DDR_DIF) ? ~fs_nxt : 1'b0;
				b1_nxt  = '0;
				b2_nxt  = '0;
				f1_nxt  = 1'b0;
				f2_nxt  = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_r                 <= '0;
			fwd_clock_pos_r       <= DAF_FWD_RST;
			fwd_clock_neg_r       <= ~DAF_FWD_RST;
			ch1_bit_r             <= '0;
			ch2_bit_r             <= '0;
			ch1_range_flag_r      <= 1'b0;
			ch2_range_flag_r      <= 1'b0;
			ch1_pair_r            <= '0;
			ch1_pair_n_r          <= '0;
			ch2_pair_r            <= '0;
			ch2_pair_n_r          <= '0;
			shared_range_flag_r   <= 1'b0;
			shared_range_flag_n_r <= 1'b0;
			sample_reliable_r     <= 1'b0;
		end else begin
			cur_r                 <= cur_nxt;
			fwd_clock_pos_r       <= fwd_nxt;
			fwd_clock_neg_r       <= ~fwd_nxt;
			ch1_bit_r             <= b1_nxt;
			ch2_bit_r             <= b2_nxt;
			ch1_range_flag_r      <= f1_nxt;
			ch2_range_flag_r      <= f2_nxt;
			ch1_pair_r            <= p1_nxt;
			ch1_pair_n_r          <= p1n_nxt;
			ch2_pair_r            <= p2_nxt;
			ch2_pair_n_r          <= p2n_nxt;
			shared_range_flag_r   <= fs_nxt;
			shared_range_flag_n_r <= fsn_nxt;
			sample_reliable_r     <= rel_nxt;
		end
	end

	// ***************
	// Assertions
	// ***************
	sequence s_fwd_rise;
		$rose(fwd_clock_pos_r) && format_r != DAF_FMT_FULL && $stable(format_r);
	endsequence
	sequence s_fwd_edge;
		$changed(fwd_clock_pos_r) && format_r != DAF_FMT_FULL && $stable(format_r);
	endsequence

	property p_capture;
		@(posedge sample_strobe_pos) disable iff (!arst_n)
		(st_req_r == st_ack_s2_r) |=> st_word_r[DAF_W_CH1 +: DAF_DATA_W] == $past(ch1_sample)
			&& st_word_r[DAF_W_CH2 +: DAF_DATA_W] == $past(ch2_sample);
	endproperty
	a_capture: assert property (p_capture) else $error("Channel capture mismatch");

	property p_fmt_map;
		@(posedge clk) disable iff (!arst_n)
		(!cfg_strap_r && $past(pin_s2_r[DAF_P_FMT +: 2]) == 2'b01) |-> format_r == DAF_FMT_DDR_SE;
	endproperty
	a_fmt_map: assert property (p_fmt_map) else $error("Format setting not applied");

	property p_no_ddr_se;
		@(posedge clk) disable iff (!arst_n) cfg_strap_r |-> format_r != DAF_FMT_DDR_SE;
	endproperty
	a_no_ddr_se: assert property (p_no_ddr_se) else $error("Strapped double-rate single");

	property p_nap;
		@(posedge clk) disable iff (!arst_n)
		(idle_r == DAF_NAP_W'(NAP_CYC - 1) && !$changed(pin_s2_r[DAF_P_ACT])) |=> nap_r;
	endproperty
	a_nap: assert property (p_nap) else $error("Nap not entered");

	property p_lock;
		@(posedge sample_strobe_pos) disable iff (!arst_n)
		($rose(st_locked_r) && $past(st_dcs_s2_r)) |-> $past(st_cnt_r) == DAF_LOCK_W'(LOCK_CYC - 1);
	endproperty
	a_lock: assert property (p_lock) else $error("Lock before count");

	property p_dcs_sel;
		@(posedge clk) disable iff (!arst_n)
		$past(pin_s2_r[DAF_P_STRAP]) |-> dcs_en_r == $past(pin_s2_r[DAF_P_CS]);
	endproperty
	a_dcs_sel: assert property (p_dcs_sel) else $error("Strap stabilizer select");

	property p_fwd_pair;
		@(posedge clk) disable iff (!arst_n) fwd_clock_neg_r == !fwd_clock_pos_r;
	endproperty
	a_fwd_pair: assert property (p_fwd_pair) else $error("Clock pair not complementary");

	property p_full_fall;
		@(posedge clk) disable iff (!arst_n)
		(format_r == DAF_FMT_FULL && $stable(format_r) && $changed(ch1_bit_r))
			|-> $fell(fwd_clock_pos_r);
	endproperty
	a_full_fall: assert property (p_full_fall) else $error("Data moved off falling edge");

	property p_ddr_odd;
		@(posedge clk) disable iff (!arst_n)
		s_fwd_rise |-> ch1_pair_r == pick_bits(cur_r[DAF_W_CH1 +: DAF_DATA_W], 1'b1)
			&& ch2_pair_r == pick_bits(cur_r[DAF_W_CH2 +: DAF_DATA_W], 1'b1);
	endproperty
	a_ddr_odd: assert property (p_ddr_odd) else $error("Odd bits not on high phase");

	property p_shared;
		@(posedge clk) disable iff (!arst_n)
		s_fwd_edge |-> shared_range_flag_r == (fwd_clock_pos_r ? cur_r[DAF_W_OF1]
			: cur_r[DAF_W_OF2]) && !ch1_range_flag_r;
	endproperty
	a_shared: assert property (p_shared) else $error("Shared flag phase wrong");

	property p_diff;
		@(posedge clk) disable iff (!arst_n)
		(s_fwd_edge and format_r == DAF_FMT_DDR_DIF) |-> ch1_pair_n_r == ~ch1_pair_r
			&& shared_range_flag_n_r == !shared_range_flag_r;
	endproperty
	a_diff: assert property (p_diff) else $error("Differential pair mismatch");

	property p_latency;
		@(posedge clk) disable iff (!arst_n)
		(fifo_out_valid && fifo_out_ready && format_r == DAF_FMT_FULL) |=>
			ch1_range_flag_r == cur_r[DAF_W_OF1] && ch1_bit_r == cur_r[DAF_W_CH1 +: DAF_DATA_W];
	endproperty
	a_latency: assert property (p_latency) else $error("Flag and data misaligned");
endmodule

// [hw/daf_pkg.sv]
// Constants, field layout and modes of the dual-channel output formatter.
// Assumes a 10 MHz control clock and a strobe clock from the converter core.
package daf_pkg;
	// ***************
	// Sample word
	// ***************
	localparam int DAF_DATA_W     = 12;
	localparam int DAF_PAIR_W     = 6;
	localparam int DAF_WORD_W     = 27;
	localparam int DAF_W_CH1      = 0;
	localparam int DAF_W_CH2      = 12;
	localparam int DAF_W_OF1      = 24;
	localparam int DAF_W_OF2      = 25;
	localparam int DAF_W_UNREL    = 26;
	localparam int DAF_FIFO_DEPTH = 16;
	// ***************
	// Timing
	// ***************
	localparam int DAF_LOCK_CYC     = 100;
	localparam int DAF_LOCK_W       = 7;
	localparam int DAF_CLK_HZ       = 10_000_000;
	localparam int DAF_NAP_FREQ_KHZ = 500;
	localparam int DAF_NAP_CYC      = (DAF_CLK_HZ / 1000) / DAF_NAP_FREQ_KHZ;
	localparam int DAF_NAP_W        = 5;
	// ***************
	// Synchroniser bit positions
	// ***************
	localparam int DAF_P_STRAP = 0;
	localparam int DAF_P_CS    = 1;
	localparam int DAF_P_SCK   = 2;
	localparam int DAF_P_DCS   = 3;
	localparam int DAF_P_FMT   = 4;
	localparam int DAF_P_NEG   = 6;
	localparam int DAF_P_RATE  = 7;
	localparam int DAF_P_HOLD  = 8;
	localparam int DAF_P_REQ   = 9;
	localparam int DAF_P_ACT   = 10;
	localparam int DAF_P_LOCK  = 11;
	localparam int DAF_P_W     = 12;
	// ***************
	// Modes and reset values
	// ***************
	typedef enum logic [1:0] {
		DAF_FMT_FULL    = 2'b00,
		DAF_FMT_DDR_SE  = 2'b01,
		DAF_FMT_DDR_DIF = 2'b10
	} daf_fmt_type;
	localparam daf_fmt_type DAF_FMT_RST = DAF_FMT_FULL;
	localparam logic        DAF_FWD_RST = 1'b1;
endpackage

// [hw/daf_fifo.sv]
// Synchronous flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, asynchronous reset.
`timescale 1ns/1ns
module daf_fifo #(
	parameter int W     = 27,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic          push, pop;

	// ***************
	// Pointers and count
	// ***************
	always_comb begin
		in_ready  = (cnt_r != (AW+1)'(DEPTH));
		out_valid = (cnt_r != '0);
		out_data  = mem_r[rp_r];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wp_nxt    = push ? wp_r + 1'b1 : wp_r;
		rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule

// [verification/daf_rx_model.sv]
// Receiver model: rebuilds sample words from the formatter's output pins.
// Assumes pins are registered on clk and change only at its rising edge.
`timescale 1ns/1ns
module daf_rx_model import daf_pkg::*; (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire daf_fmt_type           fmt,
	input  wire logic [DAF_DATA_W-1:0] bit1,
	input  wire logic [DAF_DATA_W-1:0] bit2,
	input  wire logic [DAF_PAIR_W-1:0] p1,
	input  wire logic [DAF_PAIR_W-1:0] p1n,
	input  wire logic [DAF_PAIR_W-1:0] p2,
	input  wire logic [DAF_PAIR_W-1:0] p2n,
	input  wire logic                  of1,
	input  wire logic                  of2,
	input  wire logic                  ofs,
	input  wire logic                  ofsn,
	input  wire logic                  fwd,
	input  wire logic                  rel,
	output logic                       rx_valid,
	output logic [DAF_DATA_W-1:0]      rx_ch1,
	output logic [DAF_DATA_W-1:0]      rx_ch2,
	output logic                       rx_of1,
	output logic                       rx_of2,
	output logic                       rx_rel,
	output logic                       rx_err
);
	// ***************
	// Capture on forwarded clock
	// ***************
	logic [DAF_PAIR_W-1:0] lo1_r;
	logic [DAF_PAIR_W-1:0] lo2_r;
	logic                  lof_r;
	logic                  got_r;
	logic                  fwd_prev_r;
	daf_fmt_type           fmt_prev_r;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			got_r <= 1'b0;
			rx_valid <= 1'b0;
			rx_err <= 1'b0;
			fwd_prev_r <= DAF_FWD_RST;
			fmt_prev_r <= DAF_FMT_RST;
		end else begin
			rx_valid <= 1'b0;
			fwd_prev_r <= fwd;
			fmt_prev_r <= fmt;
			// complement pairs after a differential load
			if (fmt_prev_r == DAF_FMT_DDR_DIF && fwd != fwd_prev_r
				&& ({p1n, p2n, ofsn} !== ~{p1, p2, ofs}))
				rx_err <= 1'b1;
			if (fwd == 1'b0) begin
				lo1_r <= p1;
				lo2_r <= p2;
				lof_r <= ofs;
				rx_ch1 <= bit1;
				rx_ch2 <= bit2;
				rx_of1 <= of1;
				rx_of2 <= of2;
				rx_rel <= rel;
				got_r <= 1'b1;
			end else if (got_r) begin
				got_r <= 1'b0;
				rx_valid <= 1'b1;
				if (fmt != DAF_FMT_FULL) begin
					for (int i = 0; i < DAF_PAIR_W; i++) begin
						rx_ch1[2*i] <= lo1_r[i];
						rx_ch1[2*i+1] <= p1[i];
						rx_ch2[2*i] <= lo2_r[i];
						rx_ch2[2*i+1] <= p2[i];
					end
					rx_of2 <= lof_r;
					rx_of1 <= ofs;
				end else if ({bit1, bit2, of1, of2} !== {rx_ch1, rx_ch2, rx_of1, rx_of2})
					rx_err <= 1'b1;
			end
		end
	end
endmodule

// [verification/tb_dual_adc_output_formatter.sv]
// Testbench of the output formatter: free strobe, receiver model, config sweeps.
// Assumes a 100 ns control clock and a 12 ns strobe unrelated in phase.
`timescale 1ns/1ns
module tb_dual_adc_output_formatter import daf_pkg::*; ();
	// ***************
	// Stimulus
	// ***************
	localparam daf_fmt_type EXP_FMT [4] = '{DAF_FMT_FULL, DAF_FMT_DDR_SE, DAF_FMT_DDR_DIF,
		DAF_FMT_FULL};
	logic        clk = 1'b0, arst_n = 1'b0, stb = 1'b0, stb_run = 1'b1, neg = 1'b1;
	logic        strap = 1'b0, cs_l = 1'b0, sck_l = 1'b0, cc = 1'b0, rc = 1'b0, hold = 1'b0;
	logic [1:0]  oc = 2'b00;
	logic [11:0] cnt = 12'h000, b1, b2, r1, r2;
	logic [5:0]  p1, p1n, p2, p2n;
	logic        of1, of2, ofs, ofsn, fwd, fwdn, rel, dcs_en, locked, nap, se, lvl;
	logic        rv, ro1, ro2, rrel, rerr;
	daf_fmt_type fmt;
	int          fail_count = 0, checks_done = 0, n;
	always #50 clk = ~clk;
	always begin
		#3;
		stb = stb_run ? ~stb : 1'b0;
		#3;
	end
	always @(negedge stb) cnt <= cnt + 12'h001;
	daf_formatter #(.FIFO_DEPTH(16), .LOCK_CYC(100), .NAP_CYC(8)) i_dut (.clk(clk),
		.arst_n(arst_n), .sample_strobe_pos(stb), .sample_strobe_neg(neg), .ch1_sample(cnt),
		.ch2_sample(cnt ^ 12'h3a6), .ch1_over(cnt[0]), .ch2_over(cnt[1]),
		.config_select_strap(strap), .cs_strap_level(cs_l), .sck_strap_level(sck_l),
		.clock_ctrl_setting(cc), .output_ctrl_setting(oc), .rate_change(rc),
		.output_hold(hold), .ch1_bit_r(b1), .ch2_bit_r(b2), .ch1_pair_r(p1),
		.ch1_pair_n_r(p1n), .ch2_pair_r(p2), .ch2_pair_n_r(p2n), .ch1_range_flag_r(of1),
		.ch2_range_flag_r(of2), .shared_range_flag_r(ofs), .shared_range_flag_n_r(ofsn),
		.fwd_clock_pos_r(fwd), .fwd_clock_neg_r(fwdn), .sample_reliable_r(rel),
		.format_r(fmt), .dcs_en_r(dcs_en), .dcs_locked_r(locked), .nap_r(nap),
		.single_ended_r(se));
	daf_rx_model i_rx (.clk(clk), .arst_n(arst_n), .fmt(fmt), .bit1(b1), .bit2(b2),
		.p1(p1), .p1n(p1n), .p2(p2), .p2n(p2n), .of1(of1), .of2(of2), .ofs(ofs),
		.ofsn(ofsn), .fwd(fwd), .rel(rel), .rx_valid(rv), .rx_ch1(r1), .rx_ch2(r2),
		.rx_of1(ro1), .rx_of2(ro2), .rx_rel(rrel), .rx_err(rerr));
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk_vec(input string nm, input logic [11:0] e, input logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_fmt(input string nm, input daf_fmt_type e, input daf_fmt_type g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic set_cfg(input logic s, c, k, l, input logic [1:0] o);
		@(negedge clk);
		strap = s;
		cs_l = c;
		sck_l = k;
		cc = l;
		oc = o;
		repeat (6) @(negedge clk);
	endtask
	task automatic get_words(input int cnt_w, input logic rel_on);
		logic [11:0] prev;
		int          w;
		prev = 12'h000;
		for (int k = 0; k < cnt_w + 2; k++) begin
			w = 0;
			@(negedge clk);
			while (rv !== 1'b1 && w < 60) begin
				@(negedge clk);
				w++;
			end
			chk_bit("rx_valid", 1'b1, rv);
			if (k >= 2) begin
				chk_vec("ch2_word", r1 ^ 12'h3a6, r2);
				chk_bit("ch1_flag", r1[0], ro1);
				chk_bit("ch2_flag", r1[1], ro2);
				chk_bit("order", 1'b1, 12'(r1 - prev) inside {[1:2047]});
				if (rel_on)
					chk_bit("reliable", 1'b1, rrel);
			end
			prev = r1;
		end
		chk_bit("rx_err", 1'b0, rerr);
	endtask
	task automatic chk_pins(input daf_fmt_type f);
		@(negedge clk);
		chk_fmt("format", f, fmt);
		chk_bit("fwd_neg", ~fwd, fwdn);
		if (f == DAF_FMT_FULL)
			chk_vec("pair_idle", 12'h000, {p1, p2});
		else
			chk_vec("bit_idle", 12'h000, b1 | b2);
		chk_bit("flag_idle", 1'b0, f == DAF_FMT_FULL ? ofs : of1 | of2);
		if (f != DAF_FMT_DDR_DIF)
			chk_vec("pair_n_idle", 12'h000, {p1n, p2n});
	endtask
	task automatic relock(input logic via_rc);
		@(negedge clk);
		if (via_rc)
			rc = 1'b1;
		else
			cc = 1'b1;
		repeat (7) @(negedge clk);
		chk_bit("unlocked", 1'b0, locked);
		n = 7;
		while (locked !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk_bit("lock_span", 1'b1, n >= 12 && n <= 22);
		chk_bit("dcs_en", 1'b1, dcs_en);
		rc = 1'b0;
	endtask
	// ***************
	// Tests
	// ***************
	initial begin
		#500000;
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (2) @(negedge clk);
		chk_bit("fwd_rst", DAF_FWD_RST, fwd);
		chk_fmt("fmt_rst", DAF_FMT_RST, fmt);
		chk_bit("nap_rst", 1'b0, nap);
		@(negedge clk);
		arst_n = 1'b1;
		for (int m = 0; m < 4; m++) begin
			set_cfg(1'b0, 1'b0, 1'b0, 1'b0, 2'(m));
			chk_pins(EXP_FMT[m]);
			get_words(6, 1'b1);
		end
		set_cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'b01);
		chk_pins(DAF_FMT_FULL);
		get_words(4, 1'b1);
		set_cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'b01);
		chk_pins(DAF_FMT_DDR_DIF);
		get_words(4, 1'b1);
		set_cfg(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
		// stabilizer only at full strobe rate
		relock(1'b0);
		relock(1'b1);
		get_words(4, 1'b0);
		set_cfg(1'b1, 1'b1, 1'b0, 1'b0, 2'b00);
		chk_bit("dcs_strap_on", 1'b1, dcs_en);
		set_cfg(1'b1, 1'b0, 1'b0, 1'b1, 2'b00);
		chk_bit("dcs_strap_off", 1'b0, dcs_en);
		chk_bit("locked_off", 1'b1, locked);
		hold = 1'b1;
		repeat (100) @(negedge clk);
		lvl = fwd;
		repeat (4) @(negedge clk);
		chk_bit("fwd_hold", lvl, fwd);
		hold = 1'b0;
		get_words(24, 1'b0);
		stb_run = 1'b0;
		repeat (16) @(negedge clk);
		chk_bit("nap_on", 1'b1, nap);
		stb_run = 1'b1;
		repeat (5) @(negedge clk);
		chk_bit("nap_off", 1'b0, nap);
		neg = 1'b0;
		repeat (4) @(negedge clk);
		chk_bit("se_on", 1'b1, se);
		get_words(4, 1'b0);
		neg = 1'b1;
		repeat (4) @(negedge clk);
		chk_bit("se_off", 1'b0, se);
		end_sim();
	end
endmodule
